// *** logic/tpg_group.sv ***
// design: one group of pulse_gen_unit channels with shared page cache
`timescale 1ns/100ps
`default_nettype none
module tpg_group
  import tpg_pkg::*;
#(
  parameter int          NUM_PAGES = 16,
  parameter int          GROUP_W   = 1,
  parameter logic [0:0]  GROUP_ID  = 1'h0
) (
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  input  wire tpg_pkg::tpg_bus_t   bus_in,
  input  wire logic [PAGE_W-1:0]   xfer_page,
  input  wire logic                xfer_start,
  input  wire logic                fire_strobe_n,
  output logic                     xfer_busy,
  output logic                     firing,
  output tpg_pkg::tpg_drive_t      drive [4]
);
  import tpg_pkg::*;

  localparam int LU = 4;

  typedef struct packed {
    tpg_state_t                       st;
    logic [WIDX_W+2:0]                widx;
    logic [PAGE_W-1:0]                pg;
    logic                             fire_d;
    logic [LU*NUM_CH*4-1:0][REG_W-1:0] regs;
    logic [LU*NUM_CH-1:0][REG_W-1:0]  cnt;
    logic [LU*NUM_CH-1:0][REG_W-1:0]  pulses;
    logic [LU*NUM_CH-1:0]             act;
    logic [LU*NUM_CH-1:0]             hi;
    logic [LU*NUM_CH-1:0]             lo;
    logic [LU*NUM_CH-1:0]             clamp;
    logic                             busy;
    logic                             firing;
  } tpg_grp_t;

  tpg_grp_t s_r;
  tpg_grp_t s_nxt;

  logic [CACHE_W-1:0] cache_mem [NUM_PAGES*LU*WORDS_PER_UNIT];
  logic [CACHE_W-1:0] cache_q;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic unit_hit(input logic [USEL_W-1:0] u);
    unit_hit = (u[USEL_W-1 -: GROUP_W] == GROUP_ID);
  endfunction

  function automatic int reg_idx(input logic [1:0] lu, input logic [3:0] ch, input logic [1:0] f);
    reg_idx = int'({lu, ch, f});
  endfunction

  function automatic int reg_pos(input int ch_flat, input logic [FSEL_W-1:0] f);
    reg_pos = ch_flat * 4 + int'(f);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // one clock of a channel: start delay, then width high, rest of period low
  function automatic void chan_step(
    input  logic [REG_W-1:0] period,
    input  logic [REG_W-1:0] width,
    input  logic [REG_W-1:0] cnt_in,
    input  logic [REG_W-1:0] pulses_in,
    input  logic             act_in,
    output logic [REG_W-1:0] cnt_out,
    output logic [REG_W-1:0] pulses_out,
    output logic             act_out,
    output logic             hi_out,
    output logic             lo_out
  );
    cnt_out    = cnt_in;
    pulses_out = pulses_in;
    act_out    = act_in;
    hi_out     = 1'b0;
    lo_out     = 1'b0;
    if (pulses_in == CNT_ZERO) begin
      // train over or channel unused: both halves off
      act_out = 1'b0;
    end else if (!act_in) begin
      if (cnt_in != CNT_ZERO) begin
        cnt_out = cnt_in - CNT_ONE;
      end else begin
        act_out = 1'b1;
        cnt_out = period;
      end
    end else begin
      hi_out = (cnt_in > (period - width));
      lo_out = !hi_out && (cnt_in != CNT_ZERO);
      if (cnt_in == CNT_ONE) begin
        cnt_out    = period;
        pulses_out = pulses_in - CNT_ONE;
      end else begin
        cnt_out = cnt_in - CNT_ONE;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // cache: written from the bus, read during page copy
  logic [1:0] rd_unit;
  logic [WIDX_W-1:0] rd_word;
  assign rd_unit = s_r.widx[WIDX_W+1:WIDX_W];
  assign rd_word = s_r.widx[WIDX_W-1:0];

  always_ff @(posedge sys_clk) begin
    if (bus_in.wr && bus_in.to_cache && unit_hit(bus_in.unit_sel)) begin
      cache_mem[(int'(bus_in.page) % NUM_PAGES) * LU * WORDS_PER_UNIT
                + int'(bus_in.unit_sel[1:0]) * WORDS_PER_UNIT
                + int'({bus_in.chan, bus_in.register_select_code})] <= bus_in.data;
    end
    cache_q <= cache_mem[(int'(s_r.pg) % NUM_PAGES) * LU * WORDS_PER_UNIT
                         + int'(rd_unit) * WORDS_PER_UNIT + int'(rd_word)];
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  logic fire_edge;
  always_comb begin
    s_nxt     = s_r;
    fire_edge = !fire_strobe_n && !s_r.fire_d;
    s_nxt.fire_d = !fire_strobe_n;
    // direct register writes
    if (bus_in.wr && !bus_in.to_cache && unit_hit(bus_in.unit_sel) && s_r.st == ST_IDLE) begin
      s_nxt.regs[reg_idx(bus_in.unit_sel[1:0], bus_in.chan, bus_in.register_select_code)] =
        bus_in.data[REG_W-1:0];
    end
    case (s_r.st)
      ST_IDLE: begin
        // a copy request wins over a trigger in the same cycle
        if (xfer_start) begin
          s_nxt.st   = ST_XFER;
          s_nxt.pg   = xfer_page;
          s_nxt.widx = '0;
          s_nxt.busy = 1'b1;
        end else if (fire_edge) begin
          s_nxt.st     = ST_FIRE;
          s_nxt.firing = 1'b1;
          for (int i = 0; i < LU*NUM_CH; i++) begin
            s_nxt.cnt[i]    = s_r.regs[reg_pos(i, SEL_DELAY)];
            s_nxt.pulses[i] = s_r.regs[reg_pos(i, SEL_COUNT)];
            s_nxt.act[i]    = 1'b0;
          end
        end
      end
      ST_XFER: begin
        // one read cycle of latency: store the previous word
        if (s_r.widx != '0) begin
          s_nxt.regs[int'(s_r.widx) - 1] = cache_q[REG_W-1:0];
        end
        if (s_r.widx == (WIDX_W+3)'(LU*WORDS_PER_UNIT)) begin
          s_nxt.st   = ST_IDLE;
          s_nxt.busy = 1'b0;
        end else begin
          s_nxt.widx = s_r.widx + 1'b1;
        end
      end
      ST_FIRE: begin
        // every channel steps on its own counters
        for (int i = 0; i < LU*NUM_CH; i++) begin
          chan_step(s_r.regs[reg_pos(i, SEL_PERIOD)],
                    s_r.regs[reg_pos(i, SEL_WIDTH)],
                    s_r.cnt[i],
                    s_r.pulses[i],
                    s_r.act[i],
                    s_nxt.cnt[i],
                    s_nxt.pulses[i],
                    s_nxt.act[i],
                    s_nxt.hi[i],
                    s_nxt.lo[i]);
        end
        if (s_r.pulses == '0) begin
          s_nxt.st     = ST_IDLE;
          s_nxt.firing = 1'b0;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // clamp whenever neither half drives
    s_nxt.clamp = ~(s_nxt.hi | s_nxt.lo);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      // all halves off and every clamp on
      s_r <= '0;
      s_r.clamp <= CLAMP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs: straight from the state flops
  genvar u;
  generate
    for (u = 0; u < LU; u++) begin : g_unit
      assign drive[u].hi    = s_r.hi[u*NUM_CH +: NUM_CH];
      assign drive[u].lo    = s_r.lo[u*NUM_CH +: NUM_CH];
      assign drive[u].clamp = s_r.clamp[u*NUM_CH +: NUM_CH];
    end
  endgenerate

  assign xfer_busy = s_r.busy;
  assign firing    = s_r.firing;
endmodule // tpg_group
`default_nettype wire

// *** logic/tpg_pkg.sv ***
// package: constants and carrier types for the transmit pulse generator group
package tpg_pkg;
  localparam int NUM_CH        = 16;
  localparam int NUM_UNITS     = 8;
  localparam int REG_W         = 11;
  localparam int CACHE_W       = 12;
  localparam int FSEL_W        = 2;
  localparam int CSEL_W        = 4;
  localparam int USEL_W        = 3;
  localparam int PAGE_W        = 10;
  localparam int WORDS_PER_UNIT = 64;
  localparam int WIDX_W        = 6;
  // register select codes
  localparam logic [1:0] SEL_DELAY  = 2'h0;
  localparam logic [1:0] SEL_WIDTH  = 2'h1;
  localparam logic [1:0] SEL_PERIOD = 2'h2;
  localparam logic [1:0] SEL_COUNT  = 2'h3;
  localparam logic [10:0] REG_RST   = 11'h000;
  localparam logic [10:0] CNT_ZERO  = 11'h000;
  localparam logic [10:0] CNT_ONE   = 11'h001;
  localparam logic [63:0] CLAMP_RST = 64'hFFFF_FFFF_FFFF_FFFF;

  typedef struct packed {
    logic                wr;
    logic                to_cache;
    logic [USEL_W-1:0]   unit_sel;
    logic [PAGE_W-1:0]   page;
    logic [FSEL_W-1:0]   register_select_code;
    logic [CSEL_W-1:0]   chan;
    logic [CACHE_W-1:0]  data;
  } tpg_bus_t;

  typedef struct packed {
    logic [NUM_CH-1:0] hi;
    logic [NUM_CH-1:0] lo;
    logic [NUM_CH-1:0] clamp;
  } tpg_drive_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_FIRE = 2'b10
  } tpg_state_t;
endpackage

// *** test/testbench.sv ***
// testbench: random pulse programs through cache and registers
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("unexpected %0t %h %h", $time, a, b); end end
module testbench;
  import tpg_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, xfer_start, fire_strobe_n, xfer_busy, firing;
  tpg_bus_t bus_in;
  logic [PAGE_W-1:0] xfer_page;
  tpg_drive_t drive [4];
  int fails = 0, cmp_count = 0, hic [2], loc [2], first [2];
  logic [15:0] seed = 16'hFA35;
  logic [10:0] prm [2][4];
  logic [1:0] tu [2];
  logic [3:0] tc [2];
  always #5 sys_clk = ~sys_clk;
  tpg_fe_model tpg_fe_model_inst (.sys_clk, .bus_in, .xfer_page, .xfer_start, .fire_strobe_n);
  tpg_group tpg_group_inst (.sys_clk, .arst_n, .bus_in, .xfer_page, .xfer_start, .fire_strobe_n,
    .xfer_busy, .firing, .drive);
  function automatic logic [10:0] rnd(input int m);
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return 11'(seed % m) + 11'h001;
  endfunction
  // expected cycles: one phase length times the pulse count
  function automatic logic [31:0] exp_len(input logic [10:0] len, input logic [10:0] n);
    return 32'(int'(len) * int'(n));
  endfunction
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic go();
    hic = '{0, 0};
    loc = '{0, 0};
    first = '{-1, -1};
    fork
      tpg_fe_model_inst.fire();
      begin
        @(posedge sys_clk);
        tpg_fe_model_inst.copy(10'h000);
      end
    join_none
    for (int t = 0; t < 400; t++) begin
      @(negedge sys_clk);
      for (int k = 0; k < 2; k++) begin
        hic[k] += int'(drive[tu[k]].hi[tc[k]] === 1'b1);
        loc[k] += int'(drive[tu[k]].lo[tc[k]] === 1'b1);
        if (first[k] < 0 && drive[tu[k]].hi[tc[k]] === 1'b1) first[k] = t;
      end
    end
    for (int k = 0; k < 2; k++) begin
      `CHK(32'(hic[k]), exp_len(prm[k][1], prm[k][3]))
      `CHK(32'(loc[k]), exp_len(prm[k][2] - prm[k][1], prm[k][3]))
      `CHK(drive[tu[k]].clamp, 16'hFFFF)
    end
    `CHK(32'(first[1] - first[0]), 32'(int'(prm[1][0]) - int'(prm[0][0])))
    `CHK(firing, 1'b0)
    `CHK(xfer_busy, 1'b0)
  endtask
  initial begin
    logic [9:0] pg;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      pg = 10'(rnd(16) - 11'h001);
      tu[0] = 2'(rnd(4));
      tu[1] = tu[0] ^ 2'h3;
      for (int k = 0; k < 2; k++) begin
        tc[k] = 4'(rnd(16));
        prm[k][0] = rnd(16);
        prm[k][1] = rnd(4);
        prm[k][2] = prm[k][1] + rnd(4);
        prm[k][3] = rnd(3);
      end
      if (r == 3) prm[1] = '{11'h010, 11'h004, 11'h008, 11'h003};
      if (r % 2 == 0) begin
        for (int i = 0; i < 256; i++) tpg_fe_model_inst.wr(1'b1, 3'(i[7:6]), pg, i[1:0], i[5:2], 12'h000);
        for (int i = 0; i < 8; i++) tpg_fe_model_inst.wr(1'b1, {1'b0, tu[i/4]}, pg, 2'(i), tc[i/4], {1'b0, prm[i/4][i%4]});
        tpg_fe_model_inst.copy(pg);
      end else begin
        for (int i = 0; i < 8; i++) begin
          tpg_fe_model_inst.wr(1'b0, {1'b0, tu[i/4]}, 10'h000, 2'(i), tc[i/4], {1'b0, prm[i/4][i%4]});
          tpg_fe_model_inst.wr(1'b0, {1'b1, tu[i/4]}, 10'h000, 2'(i), tc[i/4], 12'h7FF);
        end
      end
      go();
    end
    results();
  end
  initial begin
    #300000;
    fails++;
    results();
  end
endmodule // testbench
`default_nettype wire

// *** test/tpg_fe_model.sv ***
// front-end controller model: bus writes, page copy, fire strobe
`timescale 1ns/100ps
`default_nettype none
module tpg_fe_model
  import tpg_pkg::*;
(
  input  wire logic          sys_clk,
  output tpg_pkg::tpg_bus_t  bus_in,
  output logic [PAGE_W-1:0]  xfer_page,
  output logic               xfer_start,
  output logic               fire_strobe_n
);
  initial begin
    bus_in = '0;
    xfer_page = '0;
    xfer_start = 1'b0;
    fire_strobe_n = 1'b1;
  end
  // one-cycle write, released lines inverted
  task automatic wr(input logic c, input logic [2:0] u, input logic [9:0] pg, input logic [1:0] f,
    input logic [3:0] ch, input logic [11:0] d);
    @(posedge sys_clk);
    bus_in <= '{1'b1, c, u, pg, f, ch, d};
    @(posedge sys_clk);
    bus_in <= {1'b0, ~bus_in[31:0]};
  endtask
  // page copy request, then a 300-clock wait that covers the 257-cycle copy
  task automatic copy(input logic [9:0] pg);
    @(posedge sys_clk);
    xfer_page <= pg;
    xfer_start <= 1'b1;
    @(posedge sys_clk);
    xfer_start <= 1'b0;
    repeat (300) @(posedge sys_clk);
  endtask
  task automatic fire();
    @(posedge sys_clk);
    fire_strobe_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    fire_strobe_n <= 1'b1;
  endtask
endmodule // tpg_fe_model
`default_nettype wire

// *** test/tpg_group_asserts.sv ***
// checker: port properties of the pulse generator group
`timescale 1ns/100ps
`default_nettype none
module tpg_group_asserts
  import tpg_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              arst_n,
  input wire logic              xfer_start,
  input wire logic              fire_strobe_n,
  input wire logic              xfer_busy,
  input wire logic              firing,
  input wire tpg_pkg::tpg_drive_t drive [4]
);
  logic ovl, drv, cok;
  always_comb begin
    ovl = 1'b0;
    drv = 1'b0;
    cok = 1'b1;
    for (int u = 0; u < 4; u++) begin
      ovl = ovl | (|(drive[u].hi & drive[u].lo));
      drv = drv | (|(drive[u].hi | drive[u].lo));
      cok = cok & (drive[u].clamp == ~(drive[u].hi | drive[u].lo));
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_no_overlap: assert property (!ovl) else $error("halves overlap");
  a_clamp_rest: assert property (cok) else $error("clamp wrong");
  a_copy_start: assert property (!xfer_busy && !firing && xfer_start |=> xfer_busy) else $error("no copy");
  a_copy_span: assert property ($rose(xfer_busy) |-> ##256 xfer_busy ##1 !xfer_busy) else $error("copy len");
  a_fire_start: assert property (!xfer_busy && !firing && !xfer_start && $fell(fire_strobe_n) |-> ##[1:2] firing)
    else $error("no fire");
  a_copy_excl: assert property (!(xfer_busy && firing)) else $error("copy during fire");
  a_drive_fire: assert property (drv |-> firing || $past(firing)) else $error("stray pulse");
  a_busy_refuse: assert property (firing && xfer_start |=> !xfer_busy) else $error("copy accepted");
endmodule // tpg_group_asserts
bind tpg_group tpg_group_asserts tpg_group_asserts_inst (.sys_clk, .arst_n, .xfer_start, .fire_strobe_n,
  .xfer_busy, .firing, .drive);
`default_nettype wire
